// ===== design/bbv_pkg.sv
// Constants, types and helpers of the buck-boost voltage control
// Operation
// - Enable below 0.4V: shutdown, registers to default
// - Bus access only after 100us enable deglitch
// - Enable below low threshold inhibits switching
// - Enable high with supply ok starts soft-start
// - Power fault held during soft-start until good
// - Select low uses low code, default 3.3V
// - Select high uses high code, default 3.45V
// - Target equals 2.025V plus code times 25mV
// - Range 2.025V to 5.2V, 25mV steps
// - Rate field picks 1/2.5/5/10 V/ms, both directions
// - Select change ramps output at chosen rate
// - Ramp bit forces fixed frequency while ramping
// - Forced fixed-frequency bit gives continuous conduction
// - Ultra-sonic bit keeps switching above 30kHz
// - Default is automatic light-load pulse skipping
// - Fault set when not good; read clears if good
// - Output discharged whenever enable is low
// - Power-on reset loads default voltage codes
// - Rate codes 00/01/10/11 in register 0x01
// - Serial target address is 0x75
package bbv_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_CONTROL = 8'h01;
    localparam logic [7:0] REG_STATUS = 8'h02;
    localparam logic [7:0] REG_LOW_CODE = 8'h04;
    localparam logic [7:0] REG_HIGH_CODE = 8'h05;
    localparam logic [6:0] I2C_TARGET_ADDR = 7'h75;

    // ==========================================================
    // Field positions
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_RATE_MSB = 1;
    localparam int CTRL_RAMP_PWM_BIT = 2;
    localparam int CTRL_FORCED_FIXED_FREQUENCY_BIT_BIT = 3;
    localparam int CTRL_USONIC_BIT = 4;
    localparam int STAT_FAULT_BIT = 0;
    localparam int CODE_W = 7;

    // ==========================================================
    // Reset values
    localparam logic [4:0] CONTROL_RESET = 5'h00;
    localparam logic [6:0] LOW_CODE_RESET = 7'h33;
    localparam logic [6:0] HIGH_CODE_RESET = 7'h39;
    localparam logic FAULT_RESET = 1'b1;

    // ==========================================================
    // Ramp rate encodings
    localparam logic [1:0] RATE_1V_MS = 2'b00;
    localparam logic [1:0] RATE_2V5_MS = 2'b01;
    localparam logic [1:0] RATE_5V_MS = 2'b10;
    localparam logic [1:0] RATE_10V_MS = 2'b11;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int DEGLITCH_US = 100;
    localparam int DEGLITCH_CYC = (DEGLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VOUT_BASE_MV = 2025;
    localparam int VOUT_STEP_MV = 25;
    localparam int RATE0_MV_PER_MS = 1000;
    localparam int RATE1_MV_PER_MS = 2500;
    localparam int RATE2_MV_PER_MS = 5000;
    localparam int RATE3_MV_PER_MS = 10000;
    localparam int STEP_SCALE = VOUT_STEP_MV * 1000000 / CLK_PERIOD_NS;
    localparam int STEP0_CYC = STEP_SCALE / RATE0_MV_PER_MS;
    localparam int STEP1_CYC = STEP_SCALE / RATE1_MV_PER_MS;
    localparam int STEP2_CYC = STEP_SCALE / RATE2_MV_PER_MS;
    localparam int STEP3_CYC = STEP_SCALE / RATE3_MV_PER_MS;

    // ==========================================================
    // Serial engine states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_PTR = 4'h3,
        ST_PTR_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RACK = 4'h8
    } bbv_i2c_state_t;

    // Code to millivolts, 13 bits covers 5200
    function automatic logic [12:0] code_to_mv(input logic [6:0] code);
        return 13'(VOUT_BASE_MV) + 13'(code) * 13'(VOUT_STEP_MV);
    endfunction : code_to_mv

endpackage : bbv_pkg

// ===== design/bbv_ramp_stepper.sv
// Slew-limited stepper toward the selected code
`timescale 1ns/1ps
`default_nettype none
module bbv_ramp_stepper #(
    parameter int CW = 7,
    parameter int CNT_W = 16,
    parameter int STEP_SLOW = 5000,
    parameter int STEP_MID = 2000,
    parameter int STEP_FAST = 1000,
    parameter int STEP_TOP = 500
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [CW-1:0] target_code,
    input wire logic [1:0] rate_sel,
    output logic [CW-1:0] current_code,
    output logic ramping
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] interval;
    logic [CW-1:0] cur_q;
    logic busy_q;

    // ==========================================================
    // Interval per rate code
    always_comb begin
        unique case (rate_sel)
            bbv_pkg::RATE_1V_MS: interval = CNT_W'(STEP_SLOW);
            bbv_pkg::RATE_2V5_MS: interval = CNT_W'(STEP_MID);
            bbv_pkg::RATE_5V_MS: interval = CNT_W'(STEP_FAST);
            bbv_pkg::RATE_10V_MS: interval = CNT_W'(STEP_TOP);
        endcase
    end

    // ==========================================================
    // Stepping, same interval up and down
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= bbv_pkg::LOW_CODE_RESET;
            cnt_q <= '0;
        end else if (load) begin
            cur_q <= target_code;
            cnt_q <= '0;
        end else if (cur_q == target_code) begin
            cnt_q <= '0;
        end else if (cnt_q >= interval - CNT_W'(1)) begin
            cnt_q <= '0;
            if (cur_q < target_code) begin
                cur_q <= cur_q + CW'(1);
            end else begin
                cur_q <= cur_q - CW'(1);
            end
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= !load && (cur_q != target_code);
        end
    end

    assign current_code = cur_q;
    assign ramping = busy_q;

endmodule : bbv_ramp_stepper
`default_nettype wire

// ===== design/bbv_voltage_control.sv
// Buck-boost voltage control top: serial target, registers, modes
`timescale 1ns/1ps
`default_nettype none
module bbv_voltage_control #(
    parameter int DEGLITCH_CYCLES = bbv_pkg::DEGLITCH_CYC,
    parameter int DG_W = 15,
    parameter int STEP_SLOW_CYC = bbv_pkg::STEP0_CYC,
    parameter int STEP_MID_CYC = bbv_pkg::STEP1_CYC,
    parameter int STEP_FAST_CYC = bbv_pkg::STEP2_CYC,
    parameter int STEP_TOP_CYC = bbv_pkg::STEP3_CYC,
    parameter int STEP_W = 16
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic EN_ABOVE_OFF,
    input wire logic EN_HIGH,
    input wire logic UVLO_OK,
    input wire logic VOUT_GOOD,
    input wire logic VOLTAGE_SELECT_PIN,
    input wire logic SCL,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    output logic SHUTDOWN,
    output logic SWITCH_EN,
    output logic SOFT_START,
    output logic DISCHARGE_EN,
    output logic BUS_READY,
    output logic [6:0] TARGET_CODE,
    output logic [12:0] TARGET_MV,
    output logic RAMP_ACTIVE,
    output logic FORCED_PWM,
    output logic LIGHT_LOAD_PULSE_SKIPPING,
    output logic ULTRASONIC_EN,
    output logic POWER_FAULT_FLAG
);

    // ==========================================================
    // Declarations
    bbv_pkg::bbv_i2c_state_t state_q;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [7:0] ptr_q;
    logic rw_q;
    logic mack_q;
    logic drive_low_q;
    logic [4:0] ctrl_q;
    logic [6:0] low_code_q;
    logic [6:0] high_code_q;
    logic [DG_W-1:0] dg_cnt_q;
    logic fault_q, bus_ok_q, sw_en_q, soft_q, shutdown_q, discharge_q, forced_q, usonic_q;
    logic [12:0] mv_q;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic shutdown;
    logic sw_en_d;
    logic wr_fire;
    logic load_tx;
    logic status_read;
    logic [6:0] selected_voltage_code;
    logic [6:0] active_code;
    logic ramping;
    logic [7:0] rd_byte;

    // ==========================================================
    // Register read mux; unmapped offsets read zero
    function automatic logic [7:0] read_byte(input logic [7:0] offs);
        unique case (offs)
            bbv_pkg::REG_CONTROL: return {3'h0, ctrl_q};
            bbv_pkg::REG_STATUS: return {7'h00, fault_q};
            bbv_pkg::REG_LOW_CODE: return {1'b0, low_code_q};
            bbv_pkg::REG_HIGH_CODE: return {1'b0, high_code_q};
            default: return 8'h00;
        endcase
    endfunction : read_byte

    always_comb begin
        rd_byte = read_byte(ptr_q);
    end

    // ==========================================================
    // Bus condition detection, pins are already synchronous
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= SCL;
            sda_q <= SDA_IN;
        end
    end

    assign scl_rise = SCL && !scl_q;
    assign scl_fall = !SCL && scl_q;
    assign start_cond = SCL && scl_q && sda_q && !SDA_IN;
    assign stop_cond = SCL && scl_q && !sda_q && SDA_IN;
    assign shutdown = !EN_ABOVE_OFF;

    // ==========================================================
    // Enable deglitch before the bus is opened
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            dg_cnt_q <= '0;
            bus_ok_q <= 1'b0;
        end else if (!EN_HIGH || shutdown) begin
            dg_cnt_q <= '0;
            bus_ok_q <= 1'b0;
        end else if (!bus_ok_q) begin
            if (dg_cnt_q >= DG_W'(DEGLITCH_CYCLES - 1)) begin
                bus_ok_q <= 1'b1;
            end else begin
                dg_cnt_q <= dg_cnt_q + DG_W'(1);
            end
        end
    end

    // ==========================================================
    // Serial slave engine
    // Closed until deglitch: no address is acked
    assign wr_fire = bus_ok_q && !start_cond && !stop_cond && (state_q == bbv_pkg::ST_WDATA)
        && scl_fall && (bit_cnt_q == 4'h8);
    assign load_tx = bus_ok_q && !start_cond && !stop_cond && scl_fall
        && (((state_q == bbv_pkg::ST_ADDR_ACK) && rw_q) || ((state_q == bbv_pkg::ST_RACK) && mack_q));
    assign status_read = load_tx && (ptr_q == bbv_pkg::REG_STATUS);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= bbv_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            drive_low_q <= 1'b0;
        end else if (shutdown || !bus_ok_q) begin
            state_q <= bbv_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            drive_low_q <= 1'b0;
        end else if (start_cond) begin
            state_q <= bbv_pkg::ST_ADDR;
            bit_cnt_q <= 4'h0;
            drive_low_q <= 1'b0;
        end else if (stop_cond) begin
            state_q <= bbv_pkg::ST_IDLE;
            drive_low_q <= 1'b0;
        end else if (load_tx) begin
            bit_cnt_q <= 4'h0;
            tx_q <= rd_byte;
            drive_low_q <= !rd_byte[7];
            ptr_q <= ptr_q + 8'h01;
            state_q <= bbv_pkg::ST_RDATA;
        end else begin
            unique case (state_q)
                bbv_pkg::ST_IDLE: begin
                    drive_low_q <= 1'b0;
                end
                bbv_pkg::ST_ADDR, bbv_pkg::ST_PTR, bbv_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], SDA_IN};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall && bit_cnt_q == 4'h8) begin
                        bit_cnt_q <= 4'h0;
                        if (state_q == bbv_pkg::ST_ADDR) begin
                            if (shift_q[7:1] == bbv_pkg::I2C_TARGET_ADDR) begin
                                rw_q <= shift_q[0];
                                drive_low_q <= 1'b1;
                                state_q <= bbv_pkg::ST_ADDR_ACK;
                            end else begin
                                state_q <= bbv_pkg::ST_IDLE;
                            end
                        end else if (state_q == bbv_pkg::ST_PTR) begin
                            ptr_q <= shift_q;
                            drive_low_q <= 1'b1;
                            state_q <= bbv_pkg::ST_PTR_ACK;
                        end else begin
                            ptr_q <= ptr_q + 8'h01;
                            drive_low_q <= 1'b1;
                            state_q <= bbv_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                bbv_pkg::ST_ADDR_ACK, bbv_pkg::ST_PTR_ACK, bbv_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        drive_low_q <= 1'b0;
                        state_q <= (state_q == bbv_pkg::ST_ADDR_ACK) ? bbv_pkg::ST_PTR
                            : bbv_pkg::ST_WDATA;
                    end
                end
                bbv_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_q == 4'h8) begin
                            drive_low_q <= 1'b0;
                            state_q <= bbv_pkg::ST_RACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            drive_low_q <= !tx_q[6];
                        end
                    end
                end
                bbv_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        mack_q <= !SDA_IN;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        state_q <= bbv_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= bbv_pkg::ST_IDLE;
                    drive_low_q <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Writable registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= bbv_pkg::CONTROL_RESET;
            low_code_q <= bbv_pkg::LOW_CODE_RESET;
            high_code_q <= bbv_pkg::HIGH_CODE_RESET;
        end else if (shutdown) begin
            ctrl_q <= bbv_pkg::CONTROL_RESET;
            low_code_q <= bbv_pkg::LOW_CODE_RESET;
            high_code_q <= bbv_pkg::HIGH_CODE_RESET;
        end else if (wr_fire) begin
            unique case (ptr_q)
                bbv_pkg::REG_CONTROL: ctrl_q <= shift_q[4:0];
                bbv_pkg::REG_LOW_CODE: low_code_q <= shift_q[6:0];
                bbv_pkg::REG_HIGH_CODE: high_code_q <= shift_q[6:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // ==========================================================
    // Power fault flag: a pending fault beats the read-clear
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            fault_q <= bbv_pkg::FAULT_RESET;
        end else if (shutdown) begin
            fault_q <= bbv_pkg::FAULT_RESET;
        end else if (!VOUT_GOOD || soft_q) begin
            fault_q <= 1'b1;
        end else if (status_read) begin
            fault_q <= 1'b0;
        end
    end

    // ==========================================================
    // Enable, switching and soft-start
    assign sw_en_d = EN_HIGH && UVLO_OK && !shutdown;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            sw_en_q <= 1'b0;
            shutdown_q <= 1'b1;
            discharge_q <= 1'b1;
        end else begin
            sw_en_q <= sw_en_d;
            shutdown_q <= shutdown;
            discharge_q <= !EN_HIGH;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            soft_q <= 1'b0;
        end else if (!sw_en_d) begin
            soft_q <= 1'b0;
        end else if (!sw_en_q) begin
            soft_q <= 1'b1;
        end else if (VOUT_GOOD) begin
            soft_q <= 1'b0;
        end
    end

    // ==========================================================
    // Target selection and slew
    // Idle code tracks the selection
    // so soft-start aims at the live setting
    assign selected_voltage_code = VOLTAGE_SELECT_PIN ? high_code_q : low_code_q;

    bbv_ramp_stepper #(
        .CW(bbv_pkg::CODE_W),
        .CNT_W(STEP_W),
        .STEP_SLOW(STEP_SLOW_CYC),
        .STEP_MID(STEP_MID_CYC),
        .STEP_FAST(STEP_FAST_CYC),
        .STEP_TOP(STEP_TOP_CYC)
    ) u_ramp (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .load(!sw_en_q),
        .target_code(selected_voltage_code),
        .rate_sel(ctrl_q[bbv_pkg::CTRL_RATE_MSB:bbv_pkg::CTRL_RATE_LSB]),
        .current_code(active_code),
        .ramping(ramping)
    );

    // ==========================================================
    // Operating mode
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            forced_q <= 1'b0;
            usonic_q <= 1'b0;
            mv_q <= bbv_pkg::code_to_mv(bbv_pkg::LOW_CODE_RESET);
        end else begin
            forced_q <= ctrl_q[bbv_pkg::CTRL_FORCED_FIXED_FREQUENCY_BIT_BIT]
                || (ctrl_q[bbv_pkg::CTRL_RAMP_PWM_BIT] && ramping);
            usonic_q <= ctrl_q[bbv_pkg::CTRL_USONIC_BIT];
            mv_q <= bbv_pkg::code_to_mv(active_code);
        end
    end

    // ==========================================================
    // Outputs
    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = !drive_low_q;
    assign SHUTDOWN = shutdown_q;
    assign SWITCH_EN = sw_en_q;
    assign SOFT_START = soft_q;
    assign DISCHARGE_EN = discharge_q;
    assign BUS_READY = bus_ok_q;
    assign TARGET_CODE = active_code;
    assign TARGET_MV = mv_q;
    assign RAMP_ACTIVE = ramping;
    assign FORCED_PWM = forced_q;
    assign LIGHT_LOAD_PULSE_SKIPPING = !forced_q;
    assign ULTRASONIC_EN = usonic_q;
    assign POWER_FAULT_FLAG = fault_q;

endmodule : bbv_voltage_control
`default_nettype wire

// ===== dv/bbv_voltage_control_asserts.sv
// Port assertions of the voltage control
`timescale 1ns/1ps
`default_nettype none
module bbv_voltage_control_asserts #(
    parameter int DEGLITCH_CYCLES = 20
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic EN_ABOVE_OFF,
    input wire logic EN_HIGH,
    input wire logic UVLO_OK,
    input wire logic VOUT_GOOD,
    input wire logic SHUTDOWN,
    input wire logic SWITCH_EN,
    input wire logic SOFT_START,
    input wire logic DISCHARGE_EN,
    input wire logic BUS_READY,
    input wire logic [6:0] TARGET_CODE,
    input wire logic [12:0] TARGET_MV,
    input wire logic POWER_FAULT_FLAG
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [15:0] en_cnt_q;
    // ====
    // Enable run length, saturating
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            en_cnt_q <= 16'h0000;
        end else if (EN_HIGH && EN_ABOVE_OFF) begin
            en_cnt_q <= en_cnt_q + {15'h0000, ~&en_cnt_q};
        end else begin
            en_cnt_q <= 16'h0000;
        end
    end
    // ====
    // Checks
    a_shutdown_follows: assert property (1 |=> SHUTDOWN == !$past(EN_ABOVE_OFF))
        else $error("shutdown wrong");
    a_switch_gated: assert property (1 |=>
        SWITCH_EN == $past(EN_HIGH && UVLO_OK && EN_ABOVE_OFF))
        else $error("switching not gated");
    a_discharge_low: assert property (1 |=> DISCHARGE_EN == !$past(EN_HIGH))
        else $error("discharge wrong");
    a_soft_start: assert property ($rose(SWITCH_EN) |-> SOFT_START)
        else $error("no soft start");
    a_fault_set: assert property ((SOFT_START || !VOUT_GOOD) |=> POWER_FAULT_FLAG)
        else $error("fault flag not set");
    a_target_mv: assert property (1 |=>
        TARGET_MV == 13'h07E9 + 13'h0019 * 13'($past(TARGET_CODE)))
        else $error("target mV wrong");
    a_ready_wait: assert property ($rose(BUS_READY) |->
        en_cnt_q >= 16'(DEGLITCH_CYCLES - 1) && en_cnt_q <= 16'(DEGLITCH_CYCLES + 1))
        else $error("bus ready at wrong time");
    a_step_single: assert property (($past(SWITCH_EN) && $changed(TARGET_CODE))
        |-> (TARGET_CODE == $past(TARGET_CODE) + 7'h01 || TARGET_CODE == $past(TARGET_CODE) - 7'h01))
        else $error("ramp jumped");
endmodule : bbv_voltage_control_asserts
bind bbv_voltage_control bbv_voltage_control_asserts #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) i_asserts (.*);
`default_nettype wire

// ===== dv/bbv_i2c_host.sv
// Serial bus host model
`timescale 1ns/1ps
`default_nettype none
module bbv_i2c_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ====
    // SCL quarter period is two clocks
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w
    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        w(2);
        scl <= 1'b1;
        w(2);
        r = sda;
        w(2);
        scl <= 1'b0;
        w(2);
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ab, a);
    endtask : xfer
    task automatic cond(input logic s);
        w(1);
        sda_low <= s;
        w(2);
        scl <= 1'b1;
        w(4);
        sda_low <= !s;
        w(4);
        if (!s) begin
            scl <= 1'b0;
            w(2);
        end
    endtask : cond
    // Reads set the pointer, then restart
    task automatic acc(input logic rd, input logic [7:0] p, input logic [7:0] wd,
                       output logic [7:0] q, output logic ok);
        logic [3:0] a;
        cond(1'b0);
        xfer(8'hEA, 1'b1, q, a[0]);
        xfer(p, 1'b1, q, a[1]);
        if (rd) cond(1'b0);
        xfer(rd ? 8'hEB : wd, 1'b1, q, a[2]);
        if (rd) xfer(8'hFF, 1'b1, q, a[3]);
        cond(1'b1);
        ok = a[2:0] == 3'b000;
    endtask : acc
endmodule : bbv_i2c_host
`default_nettype wire

// ===== dv/tb_bbv_voltage_control.sv
// Testbench of the buck-boost voltage control
`timescale 1ns/1ps
`default_nettype none
module tb_bbv_voltage_control;
    localparam int DG = 20;
    localparam int STEPS [4] = '{8, 6, 4, 2};
    logic clk_sys, rst_n, en_off, en_hi, uvlo, vgood, voltage_select_pin, scl, sda_low, sda_w;
    logic sda_out, sda_oe_n, shutdown, switch_en, soft_start, discharge_en, bus_ready;
    logic ramp_active, forced_pwm, light_load, ultrasonic_en, fault;
    logic [6:0] target_code;
    logic [12:0] target_mv;
    int errors;
    int num_checks;
    // Open drain with pull-up
    assign sda_w = !(sda_low || (!sda_oe_n && !sda_out));
    always #2.5 clk_sys = ~clk_sys;
    bbv_voltage_control #(
        .DEGLITCH_CYCLES(DG), .STEP_SLOW_CYC(STEPS[0]), .STEP_MID_CYC(STEPS[1]),
        .STEP_FAST_CYC(STEPS[2]), .STEP_TOP_CYC(STEPS[3])
    ) i_bbv_voltage_control (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .EN_ABOVE_OFF(en_off), .EN_HIGH(en_hi),
        .UVLO_OK(uvlo), .VOUT_GOOD(vgood), .VOLTAGE_SELECT_PIN(voltage_select_pin), .SCL(scl),
        .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SHUTDOWN(shutdown),
        .SWITCH_EN(switch_en), .SOFT_START(soft_start), .DISCHARGE_EN(discharge_en),
        .BUS_READY(bus_ready), .TARGET_CODE(target_code), .TARGET_MV(target_mv),
        .RAMP_ACTIVE(ramp_active), .FORCED_PWM(forced_pwm),
        .LIGHT_LOAD_PULSE_SKIPPING(light_load), .ULTRASONIC_EN(ultrasonic_en),
        .POWER_FAULT_FLAG(fault)
    );
    bbv_i2c_host i_bbv_i2c_host (.clk(clk_sys), .sda(sda_w), .scl(scl), .sda_low(sda_low));
    // ====
    // Helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic rw(input logic rd, input logic [7:0] p, input logic [7:0] d);
        logic [7:0] q;
        logic ok;
        i_bbv_i2c_host.acc(rd, p, d, q, ok);
        chk(16'({ok, rd ? q : d}), 16'({1'b1, d}));
    endtask : rw
    // ====
    // Scenarios
    task automatic t_reset();
        logic [7:0] q;
        logic ok;
        @(negedge clk_sys);
        chk(16'({shutdown, discharge_en, switch_en, bus_ready, fault, light_load}), 16'h0033);
        chk(16'(target_mv), 16'h0CE4);
        i_bbv_i2c_host.acc(1'b1, 8'h04, 8'h00, q, ok);
        chk(16'(ok), 16'h0000);
    endtask : t_reset
    task automatic t_enable();
        int n;
        cyc(1);
        vgood <= 1'b0;
        en_off <= 1'b1;
        uvlo <= 1'b1;
        cyc(3);
        @(negedge clk_sys);
        chk(16'(switch_en), 16'h0000);
        cyc(1);
        en_hi <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (bus_ready !== 1'b1 && n < 200);
        chk(16'(n >= DG && n <= DG + 2), 16'h0001);
        chk(16'({switch_en, soft_start, discharge_en, fault}), 16'h000D);
        cyc(1);
        vgood <= 1'b1;
        cyc(3);
        @(negedge clk_sys);
        chk(16'({soft_start, fault}), 16'h0001);
        rw(1'b1, 8'h02, 8'h01);
        rw(1'b1, 8'h02, 8'h00);
        vgood <= 1'b0;
        cyc(2);
        rw(1'b1, 8'h02, 8'h01);
        vgood <= 1'b1;
        cyc(2);
        rw(1'b1, 8'h02, 8'h01);
        rw(1'b1, 8'h02, 8'h00);
    endtask : t_enable
    task automatic t_regs();
        rw(1'b1, 8'h05, 8'h39);
        rw(1'b1, 8'h01, 8'h00);
        rw(1'b0, 8'h01, 8'hFF);
        rw(1'b1, 8'h01, 8'h1F);
        @(negedge clk_sys);
        chk(16'({forced_pwm, light_load, ultrasonic_en}), 16'h0005);
        rw(1'b0, 8'h01, 8'h00);
        rw(1'b1, 8'h03, 8'h00);
        @(negedge clk_sys);
        chk(16'({forced_pwm, light_load, ultrasonic_en}), 16'h0002);
        rw(1'b0, 8'h04, 8'hFF);
        rw(1'b1, 8'h04, 8'h7F);
        cyc(700);
        @(negedge clk_sys);
        chk(16'(target_mv), 16'h1450);
    endtask : t_regs
    task automatic t_shutdown();
        cyc(1);
        en_off <= 1'b0;
        en_hi <= 1'b0;
        cyc(4);
        @(negedge clk_sys);
        chk(16'({shutdown, switch_en, discharge_en, bus_ready, fault}), 16'h0015);
        chk(16'(target_mv), 16'h0CE4);
        t_enable();
        rw(1'b1, 8'h04, 8'h33);
    endtask : t_shutdown
    task automatic t_ramp();
        int n;
        logic [6:0] exp;
        for (int k = 0; k < 4; k++) begin
            rw(1'b0, 8'h01, 8'(k + 4 * (k % 2)));
            cyc(1);
            voltage_select_pin <= ~voltage_select_pin;
            exp = voltage_select_pin ? 7'h33 : 7'h39;
            n = 0;
            do begin
                @(negedge clk_sys);
                n++;
                if (n == 3) chk(16'({ramp_active, forced_pwm}), 16'(2 + k % 2));
            end while (target_code !== exp && n < 200);
            chk(16'(n >= 6 * STEPS[k] && n <= 6 * STEPS[k] + 3), 16'h0001);
            cyc(2);
            @(negedge clk_sys);
            chk(16'({ramp_active, forced_pwm}), 16'h0000);
        end
    endtask : t_ramp
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        en_off = 1'b0;
        en_hi = 1'b0;
        uvlo = 1'b0;
        vgood = 1'b0;
        voltage_select_pin = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_enable();
        t_regs();
        t_shutdown();
        t_ramp();
        finish_test();
    end
    // Hang guard, far past the run length
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        finish_test();
    end
endmodule : tb_bbv_voltage_control
`default_nettype wire
